// ---- hdl/srfm_regs.svh ----
`ifndef SRFM_REGS_SVH
`define SRFM_REGS_SVH
`define SRFM_CTRL_OFS 4'h0
`define SRFM_STAT_OFS 4'h4
`define SRFM_CTRL_CLR_BIT 0
`define SRFM_ST_SUM_BIT 0
`define SRFM_ST_BUCK_BIT 1
`define SRFM_ST_OC_BIT 2
`define SRFM_ST_UV_BIT 3
`define SRFM_ST_OV_BIT 4
`define SRFM_ST_PIN_BIT 5
`define SRFM_ST_GD_BIT 6
`define SRFM_ST_LV_BIT 7
`define SRFM_CLK_KHZ 250000
`define SRFM_OSC_KHZ 500
`define SRFM_TRIP_DLY 2
`define SRFM_HICCUP_MS 63
`endif

// ---- hdl/srfm_pkg.sv ----
`default_nettype none
package srfm_pkg;
  typedef enum logic [2:0] {
    SRFM_OFF,
    SRFM_SS,
    SRFM_RUN,
    SRFM_TRIP,
    SRFM_HICCUP
  } srfm_buck_st_t;
endpackage : srfm_pkg
`default_nettype wire

// ---- hdl/srfm_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "srfm_regs.svh"
module srfm_top #(
  parameter int HICCUP_CYC = `SRFM_HICCUP_MS * (`SRFM_CLK_KHZ)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic oc1_cmp,
  input wire logic oc2_cmp,
  input wire logic uv_cmp,
  input wire logic ov_cmp,
  input wire logic buck_ss_done,
  input wire logic rail_ss_done,
  input wire logic en_pin,
  output logic buck_cycle_current_limit,
  output logic buck_pwm_en,
  output logic buck_ss_restart,
  output logic gate_drv_en,
  output logic gate_drv_pulldown,
  output logic vcc_highvolt_regulator,
  output logic vcc_lowvolt_regulator,
  output logic mcu_supply_regulator,
  output logic mcu_low_power,
  output logic vcc_select_switch_hv,
  output logic vcc_select_switch_lv,
  output logic cp_q14_on,
  output logic cp_q23_on,
  output logic fault_out_n
);
  localparam int OSC_DIV = `SRFM_CLK_KHZ / `SRFM_OSC_KHZ;
  localparam int NIN = 7;

  // input synchronisers: 3 flops, accept once 2nd and 3rd agree
  logic [NIN-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= {en_pin, rail_ss_done, buck_ss_done, ov_cmp, uv_cmp, oc2_cmp, oc1_cmp};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
    end
  end
  logic oc1, oc2, uv, ov, bss, rss, en;
  assign {en, rss, bss, ov, uv, oc2, oc1} = filt_reg;
  // only the buck sees the lower limit
  assign buck_cycle_current_limit = oc1;

  // oscillator tick and pump phase
  logic [8:0] osc_cnt_reg;
  logic osc_tick;
  assign osc_tick = (osc_cnt_reg == 9'(OSC_DIV - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn)
      osc_cnt_reg <= '0;
    else if (osc_tick)
      osc_cnt_reg <= '0;
    else
      osc_cnt_reg <= osc_cnt_reg + 9'h1;
  end

  // buck sequencing
  srfm_pkg::srfm_buck_st_t st_reg;
  logic [1:0] trip_cnt_reg;
  logic [23:0] hic_cnt_reg;
  logic restart_reg;
  logic active;
  assign active = (st_reg == srfm_pkg::SRFM_SS) || (st_reg == srfm_pkg::SRFM_RUN);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= srfm_pkg::SRFM_OFF;
      trip_cnt_reg <= '0;
      hic_cnt_reg <= '0;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (!en) begin
        st_reg <= srfm_pkg::SRFM_OFF;
      end else begin
        case (st_reg)
          srfm_pkg::SRFM_OFF: begin
            st_reg <= srfm_pkg::SRFM_SS;
            restart_reg <= 1'b1;
          end
          srfm_pkg::SRFM_SS, srfm_pkg::SRFM_RUN: begin
            if (oc2) begin
              st_reg <= srfm_pkg::SRFM_TRIP;
              trip_cnt_reg <= '0;
            end else if (uv) begin
              st_reg <= srfm_pkg::SRFM_HICCUP;
              hic_cnt_reg <= '0;
            end else if (st_reg == srfm_pkg::SRFM_SS && bss) begin
              st_reg <= srfm_pkg::SRFM_RUN;
            end
          end
          srfm_pkg::SRFM_TRIP: begin
            if (osc_tick) begin
              trip_cnt_reg <= trip_cnt_reg + 2'h1;
              if (trip_cnt_reg == 2'(`SRFM_TRIP_DLY - 1)) begin
                st_reg <= srfm_pkg::SRFM_HICCUP;
                hic_cnt_reg <= '0;
              end
            end
          end
          srfm_pkg::SRFM_HICCUP: begin
            if (hic_cnt_reg == 24'(HICCUP_CYC - 1)) begin
              st_reg <= srfm_pkg::SRFM_SS;
              restart_reg <= 1'b1;
            end else begin
              hic_cnt_reg <= hic_cnt_reg + 24'h1;
            end
          end
          default: st_reg <= srfm_pkg::SRFM_OFF;
        endcase
      end
    end
  end
  assign buck_ss_restart = restart_reg;

  // enable low pulse ends on the rising edge
  logic en_prev_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      en_prev_reg <= 1'b0;
    else
      en_prev_reg <= en;
  end

  // register bus
  function automatic logic reg_hit(input logic [31:0] addr, input logic [3:0] ofs);
    return addr[31:4] == 28'h0 && addr[3:0] == ofs;
  endfunction : reg_hit
  logic wr_fire, clr_wr, fault_clr;
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign clr_wr = wr_fire && reg_hit(s_axi_awaddr, `SRFM_CTRL_OFS)
    && s_axi_wstrb[0] && s_axi_wdata[`SRFM_CTRL_CLR_BIT];
  assign fault_clr = clr_wr || (en && !en_prev_reg);

  // latched status; a live event wins over a clear
  logic oc_st_reg, uv_st_reg, ov_st_reg, oc_pend_reg, uv_pend_reg;
  logic oc_set, uv_set, ov_set;
  assign oc_set = oc2 && active;
  assign uv_set = uv && active;
  assign ov_set = ov && en;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_st_reg <= 1'b0;
      uv_st_reg <= 1'b0;
      ov_st_reg <= 1'b0;
    end else begin
      oc_st_reg <= oc_set || (oc_st_reg && !fault_clr);
      uv_st_reg <= uv_set || (uv_st_reg && !fault_clr);
      ov_st_reg <= ov_set || (ov_st_reg && !fault_clr);
    end
  end
  // pin hold: released by the hardware itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_pend_reg <= 1'b0;
      uv_pend_reg <= 1'b0;
    end else begin
      if (oc_set)
        oc_pend_reg <= 1'b1;
      else if (!oc2 && rss && st_reg == srfm_pkg::SRFM_RUN)
        oc_pend_reg <= 1'b0;
      if (uv_set)
        uv_pend_reg <= 1'b1;
      else if (!uv && rss && st_reg == srfm_pkg::SRFM_RUN)
        uv_pend_reg <= 1'b0;
    end
  end
  logic stat_any;
  assign stat_any = oc_st_reg || uv_st_reg || ov_st_reg;

  // rail and driver outputs, all registered except mcu_supply_regulator, which is tied high
  logic lv_on, cp_en, gd_on, pwm_on;
  logic gd_reg, lv_reg, cp_ph_reg, q14_reg, q23_reg, pwm_reg, fpin_reg;
  assign lv_on = en && st_reg == srfm_pkg::SRFM_RUN
    && !oc_pend_reg && !uv_pend_reg;
  assign cp_en = lv_on && !ov;
  assign gd_on = lv_on && !ov && !stat_any;
  assign pwm_on = active && !ov;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gd_reg <= 1'b0;
      lv_reg <= 1'b0;
      pwm_reg <= 1'b0;
      fpin_reg <= 1'b1;
    end else begin
      gd_reg <= gd_on;
      lv_reg <= lv_on;
      pwm_reg <= pwm_on || (st_reg == srfm_pkg::SRFM_TRIP && !ov);
      fpin_reg <= !(oc_pend_reg || uv_pend_reg || ov);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cp_ph_reg <= 1'b0;
      q14_reg <= 1'b0;
      q23_reg <= 1'b0;
    end else begin
      if (osc_tick)
        cp_ph_reg <= !cp_ph_reg;
      // single phase flop drives both pairs, so they cannot overlap
      q14_reg <= cp_en && cp_ph_reg;
      q23_reg <= cp_en && !cp_ph_reg;
    end
  end
  assign gate_drv_en = gd_reg;
  assign gate_drv_pulldown = !gd_reg;
  assign vcc_lowvolt_regulator = lv_reg;
  assign vcc_select_switch_lv = lv_reg;
  assign vcc_highvolt_regulator = !lv_reg;
  assign vcc_select_switch_hv = !lv_reg;
  assign mcu_supply_regulator = 1'b1;
  assign mcu_low_power = !en_prev_reg;
  assign buck_pwm_en = pwm_reg;
  assign cp_q14_on = q14_reg;
  assign cp_q23_on = q23_reg;
  assign fault_out_n = fpin_reg;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (reg_hit(s_axi_awaddr, `SRFM_CTRL_OFS)
        || reg_hit(s_axi_awaddr, `SRFM_STAT_OFS)) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0;
    stat_word[`SRFM_ST_SUM_BIT] = stat_any;
    stat_word[`SRFM_ST_BUCK_BIT] = stat_any;
    stat_word[`SRFM_ST_OC_BIT] = oc_st_reg;
    stat_word[`SRFM_ST_UV_BIT] = uv_st_reg;
    stat_word[`SRFM_ST_OV_BIT] = ov_st_reg;
    stat_word[`SRFM_ST_PIN_BIT] = !fpin_reg;
    stat_word[`SRFM_ST_GD_BIT] = gd_reg;
    stat_word[`SRFM_ST_LV_BIT] = lv_reg;
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
      if (reg_hit(s_axi_araddr, `SRFM_STAT_OFS))
        s_axi_rdata <= stat_word;
      else if (!reg_hit(s_axi_araddr, `SRFM_CTRL_OFS))
        s_axi_rresp <= 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  a_oc_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    oc_set |=> oc_st_reg ##1 !fault_out_n)
    else $error("overcurrent not latched");
  a_uv_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    uv_set |=> uv_st_reg
    && (st_reg == srfm_pkg::SRFM_HICCUP || st_reg == srfm_pkg::SRFM_TRIP))
    else $error("undervoltage not latched");
  a_ov_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    ov |=> !cp_q14_on && !cp_q23_on && !buck_pwm_en && !gate_drv_en)
    else $error("overvoltage did not halt");
  a_clear_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_any && !fault_clr |=> stat_any)
    else $error("flag cleared without clear");
  a_pump_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    !(cp_q14_on && cp_q23_on))
    else $error("pump pairs overlap");
  a_pump_half: assert property (@(posedge aclk) disable iff (!aresetn)
    osc_tick |=> cp_ph_reg != $past(cp_ph_reg))
    else $error("pump phase missed tick");
  a_ldo_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg != srfm_pkg::SRFM_RUN |=> vcc_highvolt_regulator && vcc_select_switch_hv
    && !vcc_select_switch_lv)
    else $error("vcc source select broken");
  a_lv_select: assert property (@(posedge aclk) disable iff (!aresetn)
    en && st_reg == srfm_pkg::SRFM_RUN && !oc_pend_reg && !uv_pend_reg
    |=> vcc_lowvolt_regulator && vcc_select_switch_lv && !vcc_highvolt_regulator)
    else $error("lv ldo not selected");
  a_shutdown_rails: assert property (@(posedge aclk) disable iff (!aresetn)
    !en ##1 !en |=> !vcc_lowvolt_regulator && mcu_low_power && !buck_pwm_en)
    else $error("shutdown rails wrong");
  a_trip_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_reg == srfm_pkg::SRFM_HICCUP) && $past(st_reg) == srfm_pkg::SRFM_TRIP
    |=> !buck_pwm_en)
    else $error("buck still switching in hiccup");
  a_limit_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    oc1 && !oc2 && !uv && !ov && !stat_any && !oc_pend_reg && !uv_pend_reg
    ##1 !oc2 && !uv && !ov |=> fault_out_n)
    else $error("cycle limit touched fault pin");
endmodule : srfm_top
`default_nettype wire

// ---- testbench/srfm_mcu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module srfm_mcu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pulse_req,
  input wire logic sleep_req,
  output logic en_pin
);
  logic [3:0] low_cnt_reg;
  // pulse long enough to pass the input synchroniser and filter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_reg <= 4'h0;
    end else if (pulse_req) begin
      low_cnt_reg <= 4'hf;
    end else if (low_cnt_reg != 4'h0) begin
      low_cnt_reg <= low_cnt_reg - 4'h1;
    end
  end
  assign en_pin = !sleep_req && (low_cnt_reg == 4'h0);
endmodule : srfm_mcu_model
`default_nettype wire

// ---- testbench/tb_supply_rail_fault_manager.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_supply_rail_fault_manager;
  localparam int HC = 200;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd, seed = 32'h15;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic oc1 = 1'b0, oc2 = 1'b0, uv = 1'b0, ov = 1'b0, bss = 1'b0, rss = 1'b0;
  logic pulse_req = 1'b0, sleep_req = 1'b0, en_pin;
  logic lim, pwm, rst_p, gd, pd, hv, lv, mcu, mlp, shv, slv, q14, q23, fo_n;
  int num_errors = 0, n_tests = 0, n, k, m;
  always #2 aclk = ~aclk;
  srfm_top #(.HICCUP_CYC(HC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .oc1_cmp(oc1), .oc2_cmp(oc2), .uv_cmp(uv), .ov_cmp(ov), .buck_ss_done(bss),
    .rail_ss_done(rss), .en_pin(en_pin), .buck_cycle_current_limit(lim),
    .buck_pwm_en(pwm), .buck_ss_restart(rst_p), .gate_drv_en(gd), .gate_drv_pulldown(pd),
    .vcc_highvolt_regulator(hv), .vcc_lowvolt_regulator(lv), .mcu_supply_regulator(mcu),
    .mcu_low_power(mlp), .vcc_select_switch_hv(shv), .vcc_select_switch_lv(slv),
    .cp_q14_on(q14), .cp_q23_on(q23), .fault_out_n(fo_n));
  srfm_mcu_model mcu_i (.aclk(aclk), .aresetn(aresetn), .pulse_req(pulse_req),
    .sleep_req(sleep_req), .en_pin(en_pin));
  task automatic test_done;
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic sig(input int i);
    case (i)
      0: return fo_n;
      1: return pwm;
      2: return rst_p;
      3: return gd;
      4: return q14;
      6: return awready & wready;
      7: return bvalid;
      8: return arready;
      9: return rvalid;
      default: return q14 | q23;
    endcase
  endfunction : sig
  // bounded wait at falling edges, n holds the cycles spent
  task automatic wt(input int i, input logic v, input int lim_c);
    n = 0;
    @(negedge aclk);
    while (sig(i) !== v) begin
      @(negedge aclk);
      n++;
      if (n > lim_c) begin
        chk(32'h0, 32'h1);
        test_done();
      end
    end
  endtask : wt
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] st(input int o, u, v, p, g, l);
    return {24'h0, 1'(l), 1'(g), 1'(p), 1'(v), 1'(u), 1'(o), 1'(o | u | v), 1'(o | u | v)};
  endfunction : st
  function automatic logic [9:0] pins();
    return {fo_n, gd, pd, hv, shv, lv, slv, mcu, mlp, q14 | q23};
  endfunction : pins
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wt(6, 1'b1, 50);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wt(7, 1'b1, 50);
    chk(bresp, er);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [31:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wt(8, 1'b1, 50);
    @(posedge aclk);
    arvalid <= 1'b0;
    wt(9, 1'b1, 50);
    rd = rdata;
    chk(rresp, er);
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axr
  task automatic rs(input logic [31:0] e);
    axr(32'h4, 2'b00);
    chk(rd, e);
  endtask : rs
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(negedge aclk);
    chk({hv, shv, lv, slv, mcu, fo_n}, 6'b110011);
    @(posedge aclk);
    bss <= 1'b1;
    rss <= 1'b1;
    repeat (20) @(negedge aclk);
    chk({hv, shv, lv, slv}, 4'b0011);
    axw(32'h0, xs() | 32'h1, 2'b00);
    wt(3, 1'b1, 40);
    rs(st(0, 0, 0, 0, 1, 1));
    wt(4, 1'b0, 1100);
    wt(4, 1'b1, 1100);
    m = 0;
    for (k = 0; k < 1000; k++) begin
      chk(q14 ^ q23, 32'h1);
      m += q14;
      @(negedge aclk);
    end
    chk(m, 500);
    repeat (60) begin
      @(posedge aclk);
      rd = xs();
      oc1 <= rd[0];
    end
    @(posedge aclk);
    oc1 <= 1'b1;
    repeat (8) @(negedge aclk);
    chk({lim, pins()}, 11'b11100011101);
    @(posedge aclk);
    oc1 <= 1'b0;
    rs(st(0, 0, 0, 0, 1, 1));
    for (k = 0; k < 2; k++) begin
      @(posedge aclk);
      oc2 <= (k == 0);
      uv <= (k == 1);
      wt(0, 1'b0, 20);
      repeat (2) @(negedge aclk);
      chk(pins(), 10'b0011100100);
      wt(1, 1'b0, 1100);
      if (k == 0) chk(n >= 488 && n <= 1010, 32'h1);
      @(posedge aclk);
      oc2 <= 1'b0;
      uv <= 1'b0;
      wt(2, 1'b1, HC + 20);
      chk(n >= HC - 5 && n <= HC + 5, 32'h1);
      wt(0, 1'b1, 40);
      chk(gd, 1'b0);
      rs(st(k == 0, k == 1, 0, 0, 0, 1));
      if (k == 0) begin
        axw(32'h0, xs() & 32'hfffffffe, 2'b00);
        rs(st(1, 0, 0, 0, 0, 1));
        axw(32'h0, 32'h1, 2'b00);
      end else begin
        @(posedge aclk);
        pulse_req <= 1'b1;
        @(posedge aclk);
        pulse_req <= 1'b0;
      end
      wt(3, 1'b1, 80);
      rs(st(0, 0, 0, 0, 1, 1));
    end
    @(posedge aclk);
    ov <= 1'b1;
    wt(0, 1'b0, 20);
    repeat (2) @(negedge aclk);
    chk({pins(), pwm}, 11'b00100111000);
    @(posedge aclk);
    ov <= 1'b0;
    wt(0, 1'b1, 20);
    wt(1, 1'b1, 20);
    wt(10, 1'b1, 1100);
    rs(st(0, 0, 1, 0, 0, 1));
    axw(32'h0, 32'h1, 2'b00);
    wt(3, 1'b1, 40);
    @(posedge aclk);
    sleep_req <= 1'b1;
    repeat (20) @(negedge aclk);
    chk({hv, shv, lv, slv, mcu, mlp, pwm, q14 | q23}, 8'b11001100);
    @(posedge aclk);
    sleep_req <= 1'b0;
    axr(32'h8, 2'b10);
    axw(32'h10, 32'h1, 2'b10);
    axr(32'h0, 2'b00);
    chk(rd, 32'h0);
    test_done();
  end
endmodule : tb_supply_rail_fault_manager
`default_nettype wire
